//--- verilog/ccp_pkg.sv
package ccp_pkg;

  // ****************************************
  // Register map and field layouts
  // ****************************************
  localparam logic [11:0] TRIM_ADDR = 12'h000;
  localparam logic [11:0] CTRL_ADDR = 12'h004;
  localparam logic [11:0] STAT_ADDR = 12'h008;

  typedef struct packed {
    logic [2:0] osc_range_fuses;
    logic       startup_select_low_fuse;
    logic [1:0] startup_time_fuses;
    logic       clock_output_fuse;
    logic       initial_divide_by_eight_fuse;
  } ccp_fuses_s;

  typedef struct packed {
    logic       divider_change_enable;
    logic [2:0] rsvd;
    logic [3:0] divider_select_field;
  } ccp_divctl_s;

  typedef struct packed {
    logic       change_pending;
    logic       osc_stable;
    logic       core_run;
    logic [3:0] active_select;
  } ccp_status_s;

  typedef enum logic [4:0] {
    ST_LOAD  = 5'b00001,
    ST_BASE  = 5'b00010,
    ST_EXTRA = 5'b00100,
    ST_RUN   = 5'b01000,
    ST_WAKE  = 5'b10000
  } ccp_state_e;

  // ****************************************
  // Codes, reset values and timing
  // ****************************************
  localparam logic [2:0]  XTAL_RANGE_MIN = 3'h4;
  localparam logic [3:0]  DIV1_CODE      = 4'h0;
  localparam logic [3:0]  DIV8_CODE      = 4'h3;
  localparam logic [3:0]  DIV_MAX_CODE   = 4'h8;
  localparam logic [6:0]  CTRL_LOW_ZERO  = 7'h00;
  localparam logic [2:0]  RSVD_ZERO      = 3'h0;
  localparam logic [2:0]  PCE_WINDOW     = 3'h4;
  localparam logic [7:0]  TRIM_RESET     = 8'h00;
  localparam int unsigned DIV_CNT_W      = 8;
  localparam int unsigned DOM_N          = 4;
  localparam int unsigned DLY_W          = 24;

  localparam real         CLK_PERIOD_NS  = 40.0;
  localparam real         T_SHORT_MS     = 4.1;
  localparam real         T_LONG_MS      = 65.0;
  localparam int unsigned EXTRA_SHORT_DEF =
    int'($ceil(T_SHORT_MS * 1.0e6 / CLK_PERIOD_NS));
  localparam int unsigned EXTRA_LONG_DEF =
    int'($ceil(T_LONG_MS * 1.0e6 / CLK_PERIOD_NS));
  localparam logic [DLY_W-1:0] BASE_DELAY_CK  = 24'h00000e;
  localparam logic [DLY_W-1:0] START_SHORT_CK = 24'h000102;
  localparam logic [DLY_W-1:0] START_MID_CK   = 24'h000400;
  localparam int unsigned      START_LONG_DEF = 16384;

endpackage : ccp_pkg

//--- verilog/ccp_ripple_div.sv
`timescale 1ns/1ps
module ccp_ripple_div
  import ccp_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       clear,
  input  wire logic [3:0] sel,
  output logic            tick,
  output logic            phase
);

  logic [DIV_CNT_W-1:0] cnt;
  logic [DIV_CNT_W:0]   carry;
  logic [DIV_CNT_W-1:0] mask;

  assign carry[0] = 1'b1;

  // ****************************************
  // Counter bits, each toggled by the carry below
  // ****************************************
  for (genvar i = 0; i < DIV_CNT_W; i++) begin : g_bit
    assign carry[i+1] = carry[i] & cnt[i];
    assign mask[i]    = (sel > 4'(i));
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cnt[i] <= 1'b0;
      end else if (clear) begin
        cnt[i] <= 1'b0;
      end else begin
        cnt[i] <= cnt[i] ^ carry[i];
      end
    end
  end

  // Last source cycle of a divided period
  assign tick  = ((cnt & mask) == mask);
  assign phase = (sel == DIV1_CODE) ? 1'b1 : ~cnt[3'(sel - 4'h1)];

endmodule : ccp_ripple_div

//--- verilog/ccp_clock_control.sv
// How it works
// - Upper range fuses pick crystal range
// - Low fuse with start-up fuses sets wake count
// - Reset delay is fourteen cycles plus option
// - Clock-out fuse drives system clock out
// - No clock output while reset holds
// - Clock output carries the divided clock
// - Divider slows all four clock domains
// - Division changes never glitch nor overshoot
// - New rate lands at the end of the running old period
// - Divider is a counter on source clock
// - Factory trim loads at reset, software rewrites
// - Trim top bit picks low or high range
// - Lower trim bits tune within range
// - Change enable sets only on clean write
// - Enable clears after four divided-clock ticks or a select write
// - Reserved control bits read as zero
// - Divide-by-eight fuse picks reset division
// - Any valid division accepted via unlock
// - Codes zero to eight divide by powers
//
// Local design decisions: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
module ccp_clock_control
  import ccp_pkg::*;
#(
  parameter int unsigned EXTRA_SHORT_CYC = EXTRA_SHORT_DEF,
  parameter int unsigned EXTRA_LONG_CYC  = EXTRA_LONG_DEF,
  parameter int unsigned START_LONG_CYC  = START_LONG_DEF
)(
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [11:0]      paddr,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  input  wire ccp_fuses_s       fuses,
  input  wire logic [7:0]       factory_trim,
  input  wire logic             wake_req,
  output logic                  core_reset_n,
  output logic                  osc_stable,
  output logic                  xtal_mode,
  output logic      [1:0]       xtal_gain,
  output logic                  trim_range_bit,
  output logic      [6:0]       trim_fine_bits,
  output logic      [DOM_N-1:0] domain_clk_en,
  output logic                  clock_out_pin_o,
  output logic                  clock_out_pin_oe
);

  ccp_state_e       state;
  ccp_state_e       next_state;
  ccp_fuses_s       fuse_q;
  ccp_divctl_s      wv;
  ccp_divctl_s      ctrl_view;
  ccp_status_s      stat_view;
  logic [DLY_W-1:0] dly_cnt;
  logic [DLY_W-1:0] extra_cyc;
  logic [DLY_W-1:0] start_cyc;
  logic [7:0]       osc_trim;
  logic             pce;
  logic [2:0]       pce_cnt;
  logic [3:0]       div_field;
  logic [3:0]       div_act;
  logic             pend;
  logic             tick;
  logic             phase;
  logic             phase_q;
  logic             access;
  logic             wr_ctrl;
  logic             addr_ok;
  logic             canon_set;
  logic             sel_write;
  logic             switch_now;
  logic [2:0]       dly_sel;

  // ****************************************
  // Fuse decode
  // ****************************************
  assign dly_sel = {fuse_q.startup_select_low_fuse,
                    fuse_q.startup_time_fuses};

  always_comb begin
    case (dly_sel)
      3'h0, 3'h3, 3'h6: extra_cyc = DLY_W'(EXTRA_SHORT_CYC);
      3'h1, 3'h4, 3'h7: extra_cyc = DLY_W'(EXTRA_LONG_CYC);
      default:          extra_cyc = '0;
    endcase
  end

  always_comb begin
    case (dly_sel)
      3'h0, 3'h1:       start_cyc = START_SHORT_CK;
      3'h2, 3'h3, 3'h4: start_cyc = START_MID_CK;
      default:          start_cyc = DLY_W'(START_LONG_CYC);
    endcase
  end

  // Range codes below the crystal block select other sources
  assign xtal_mode = (fuse_q.osc_range_fuses >= XTAL_RANGE_MIN);
  assign xtal_gain = 2'(fuse_q.osc_range_fuses - XTAL_RANGE_MIN);

  // ****************************************
  // Reset delay and wake sequencer
  // ****************************************
  always_comb begin
    next_state = state;
    case (state)
      ST_LOAD: next_state = ST_BASE;
      ST_BASE: begin
        if (dly_cnt == BASE_DELAY_CK - 24'h000001) begin
          next_state = (extra_cyc == '0) ? ST_RUN : ST_EXTRA;
        end
      end
      ST_EXTRA: begin
        if (dly_cnt == extra_cyc - 24'h000001) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (wake_req) begin
          next_state = ST_WAKE;
        end
      end
      ST_WAKE: begin
        if (dly_cnt == start_cyc - 24'h000001) begin
          next_state = ST_RUN;
        end
      end
      default: next_state = ST_LOAD;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_LOAD;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dly_cnt <= '0;
    end else if (next_state != state) begin
      dly_cnt <= '0;
    end else begin
      dly_cnt <= dly_cnt + 24'h000001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_reset_n <= 1'b0;
      osc_stable   <= 1'b0;
    end else begin
      core_reset_n <= (next_state == ST_RUN) || (next_state == ST_WAKE);
      osc_stable   <= (next_state == ST_RUN);
    end
  end

  // Straps are caught after release, never by the async reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fuse_q <= '0;
    end else if (state == ST_LOAD) begin
      fuse_q <= fuses;
    end
  end

  // ****************************************
  // Oscillator trim
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_trim <= TRIM_RESET;
    end else if (state == ST_LOAD) begin
      osc_trim <= factory_trim;
    end else if (access && pwrite && paddr == TRIM_ADDR) begin
      osc_trim <= pwdata[7:0];
    end
  end

  // Range select and fine tune go straight to the analog trim
  assign trim_range_bit = osc_trim[7];
  assign trim_fine_bits = osc_trim[6:0];

  // ****************************************
  // Protected division change
  // ****************************************
  assign wv        = ccp_divctl_s'(pwdata[7:0]);
  assign wr_ctrl   = access && pwrite && (paddr == CTRL_ADDR);
  assign canon_set = wr_ctrl && wv.divider_change_enable &&
                     ({wv.rsvd, wv.divider_select_field} == CTRL_LOW_ZERO);
  assign sel_write = wr_ctrl && pce && !wv.divider_change_enable;

  // Rewriting the enable inside the window changes nothing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pce     <= 1'b0;
      pce_cnt <= '0;
    end else if (canon_set && !pce) begin
      pce     <= 1'b1;
      pce_cnt <= '0;
    end else if (sel_write) begin
      pce     <= 1'b0;
      pce_cnt <= '0;
    end else if (pce && tick) begin
      if (pce_cnt == PCE_WINDOW - 3'h1) begin
        pce     <= 1'b0;
        pce_cnt <= '0;
      end else begin
        pce_cnt <= pce_cnt + 3'h1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_field <= DIV1_CODE;
    end else if (state == ST_LOAD) begin
      div_field <= fuses.initial_divide_by_eight_fuse ?
                   DIV8_CODE : DIV1_CODE;
    end else if (sel_write &&
                 wv.divider_select_field <= DIV_MAX_CODE) begin
      div_field <= wv.divider_select_field;
    end
  end

  // New factor waits for the end of the running period
  assign switch_now = tick && pend;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend <= 1'b0;
    end else if (sel_write &&
                 wv.divider_select_field <= DIV_MAX_CODE) begin
      pend <= 1'b1;
    end else if (switch_now) begin
      pend <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_act <= DIV1_CODE;
    end else if (state == ST_LOAD) begin
      div_act <= fuses.initial_divide_by_eight_fuse ?
                 DIV8_CODE : DIV1_CODE;
    end else if (switch_now) begin
      div_act <= div_field;
    end
  end

  ccp_ripple_div u_div (
    .pclk    (pclk),
    .presetn (presetn),
    .clear   (switch_now),
    .sel     (div_act),
    .tick    (tick),
    .phase   (phase)
  );

  // ****************************************
  // Clock domain enables and clock output
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      domain_clk_en <= '0;
      phase_q       <= 1'b0;
    end else begin
      domain_clk_en <= {DOM_N{tick && state == ST_RUN}};
      phase_q       <= phase;
    end
  end

  // Undivided setting can only be shown by passing the source
  assign clock_out_pin_o  = (div_act == DIV1_CODE) ?
                            pclk : phase_q;
  assign clock_out_pin_oe = fuse_q.clock_output_fuse &&
                            core_reset_n;

  // ****************************************
  // APB slave, zero wait states
  // ****************************************
  assign access  = psel && penable;
  assign addr_ok = (paddr == TRIM_ADDR) || (paddr == CTRL_ADDR) ||
                   (paddr == STAT_ADDR);
  assign pready  = 1'b1;
  assign pslverr = access && !addr_ok;

  assign ctrl_view = '{divider_change_enable: pce,
                       rsvd:                  RSVD_ZERO,
                       divider_select_field:  div_field};
  assign stat_view = '{change_pending: pend,
                       osc_stable:     osc_stable,
                       core_run:       (state == ST_RUN),
                       active_select:  div_act};

  // Read data is latched in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        TRIM_ADDR: prdata <= 32'(osc_trim);
        CTRL_ADDR: prdata <= 32'(ctrl_view);
        STAT_ADDR: prdata <= 32'(stat_view);
        default:   prdata <= '0;
      endcase
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_pce_clean_only: assert property (
    (wr_ctrl && !pce && !canon_set) |=> !pce)
    else $error("change enable set by unclean write");
  a_pce_sel_clear: assert property (
    sel_write |=> !pce)
    else $error("change enable survived select write");
  a_pce_window: assert property (
    pce |-> pce_cnt < PCE_WINDOW)
    else $error("change enable window overrun");
  a_rsvd_read: assert property (
    (psel && !penable && !pwrite && paddr == CTRL_ADDR)
      |=> prdata[6:4] == RSVD_ZERO)
    else $error("reserved control bits read nonzero");
  a_div_reset: assert property (
    (state == ST_LOAD) |=> div_act == ($past(fuses.initial_divide_by_eight_fuse)
      ? DIV8_CODE : DIV1_CODE))
    else $error("reset division wrong");
  a_div_legal: assert property (
    div_field <= DIV_MAX_CODE && div_act <= DIV_MAX_CODE)
    else $error("reserved division code in use");
  a_switch_edge: assert property (
    switch_now |=> div_act == $past(div_field) && (!tick || div_act == DIV1_CODE))
    else $error("division switch misplaced");
  a_clkout_reset: assert property (
    !core_reset_n |-> !clock_out_pin_oe)
    else $error("clock output during reset");
  a_clkout_on: assert property (
    (core_reset_n && fuse_q.clock_output_fuse) |-> clock_out_pin_oe)
    else $error("clock output missing");
  a_trim_load: assert property (
    (state == ST_LOAD) |=> osc_trim == $past(factory_trim))
    else $error("factory trim not loaded");
  a_dom_tick: assert property (
    (domain_clk_en != '0) |-> $past(tick) && $past(state) == ST_RUN)
    else $error("domain enable without divider tick");
  cov_div_change: cover property (sel_write ##[1:600] switch_now);
  cov_pce_timeout: cover property ($fell(pce) && !$past(sel_write));
  cov_wake: cover property (state == ST_WAKE ##1 state == ST_RUN);

endmodule : ccp_clock_control

//--- dv/tb_crystal_clock_prescaler_control.sv
`timescale 1ns/1ps
module tb_crystal_clock_prescaler_control
  import ccp_pkg::*;
  ;
  // ****************************************
  // Signals and design
  // ****************************************
  logic             pclk;
  logic             presetn;
  logic             psel;
  logic             penable;
  logic             pwrite;
  logic             wake_req;
  logic [11:0]      paddr;
  logic [31:0]      pwdata;
  logic [31:0]      prdata;
  logic             pready;
  logic             pslverr;
  logic             core_reset_n;
  logic             osc_stable;
  logic             xtal_mode;
  logic [1:0]       xtal_gain;
  logic             trim_range_bit;
  logic [6:0]       trim_fine_bits;
  logic [DOM_N-1:0] domain_clk_en;
  logic             clock_out_pin_o;
  logic             clock_out_pin_oe;
  ccp_fuses_s       fuses;
  logic [7:0]       factory_trim;
  logic [31:0]      rd;
  logic             err;
  int               err_total;
  int               samples_checked;
  int               seed;

  // Small delays keep the reset counts and the long wake count short
  ccp_clock_control #(
    .EXTRA_SHORT_CYC(20),
    .EXTRA_LONG_CYC (40),
    .START_LONG_CYC (30)
  ) u_ccp_clock_control (
    .pclk            (pclk),
    .presetn         (presetn),
    .paddr           (paddr),
    .psel            (psel),
    .penable         (penable),
    .pwrite          (pwrite),
    .pwdata          (pwdata),
    .prdata          (prdata),
    .pready          (pready),
    .pslverr         (pslverr),
    .fuses           (fuses),
    .factory_trim    (factory_trim),
    .wake_req        (wake_req),
    .core_reset_n    (core_reset_n),
    .osc_stable      (osc_stable),
    .xtal_mode       (xtal_mode),
    .xtal_gain       (xtal_gain),
    .trim_range_bit  (trim_range_bit),
    .trim_fine_bits  (trim_fine_bits),
    .domain_clk_en   (domain_clk_en),
    .clock_out_pin_o (clock_out_pin_o),
    .clock_out_pin_oe(clock_out_pin_oe)
  );

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : cmp

  task automatic cmp_cnt(input int got, input int lo, input int hi);
    samples_checked++;
    if (got < lo || got > hi) begin
      err_total++;
      $display("unexpected at %0t: got %h exp %h..%h", $time, got, lo, hi);
    end
  endtask : cmp_cnt

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // The wait for the answer ends once pready is high
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic chg(input logic [3:0] c);
    apb(1'b1, CTRL_ADDR, 32'h80);
    apb(1'b1, CTRL_ADDR, {28'h0, c});
  endtask : chg

  // Cycles between two divided-clock pulses
  task automatic per(output int p);
    int k;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (domain_clk_en[0] !== 1'b1 && k < 600);
    cmp(32'(domain_clk_en), (32'h1 << DOM_N) - 1);
    p = 0;
    do begin
      @(posedge pclk);
      p++;
    end while (domain_clk_en[0] !== 1'b1 && p < 600);
  endtask : per

  task automatic cop(output int p);
    logic prev;
    p = 0;
    do begin
      prev = clock_out_pin_o;
      @(posedge pclk);
      p++;
    end while (!(prev === 1'b0 && clock_out_pin_o === 1'b1) && p < 600);
  endtask : cop

  task automatic boot(input int i);
    int k;
    int ex;
    int st;
    ex = (i % 3 == 0) ? 20 : (i % 3 == 1) ? 40 : 0;
    st = (i < 2) ? 258 : (i < 5) ? 1024 : 30;
    @(posedge pclk);
    fuses        <= {3'($random(seed)), 3'(i), i[0], i[1]};
    factory_trim <= 8'($random(seed));
    presetn      <= 1'b0;
    repeat (5) begin
      @(posedge pclk);
      cmp({31'h0, clock_out_pin_oe}, 32'h0);
    end
    presetn <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (core_reset_n !== 1'b1 && k < 200);
    cmp_cnt(k, 14 + ex, 18 + ex);
    cmp({31'h0, xtal_mode}, {31'h0, fuses.osc_range_fuses[2]});
    if (fuses.osc_range_fuses[2])
      cmp({30'h0, xtal_gain}, {30'h0, fuses.osc_range_fuses[1:0]});
    cmp({31'h0, clock_out_pin_oe}, {31'h0, i[0]});
    apb(1'b0, CTRL_ADDR, 32'h0);
    cmp(rd, i[1] ? 32'h3 : 32'h0);
    apb(1'b0, TRIM_ADDR, 32'h0);
    cmp(rd, {24'h0, factory_trim});
    @(posedge pclk);
    wake_req <= 1'b1;
    @(posedge pclk);
    wake_req <= 1'b0;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (osc_stable !== 1'b1 && k < 2000);
    cmp_cnt(k, st - 1, st + 3);
  endtask : boot

  task automatic conclude();
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : conclude

  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    int p;
    int old;
    logic [7:0] v;
    seed = 32'hb0334d6b;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    wake_req = 1'b0;
    fuses = '0;
    factory_trim = 8'h00;
    err_total = 0;
    samples_checked = 0;
    for (int i = 0; i < 8; i++) boot(i);
    for (int j = 0; j < 6; j++) begin
      v = (j == 0) ? 8'h7f : (j == 1) ? 8'h80 : 8'($random(seed));
      // No memory writes run here, so any trim is allowed
      apb(1'b1, TRIM_ADDR, {24'h0, v});
      apb(1'b0, TRIM_ADDR, 32'h0);
      cmp(rd, {24'h0, v});
      cmp({24'h0, trim_range_bit, trim_fine_bits}, {24'h0, v});
    end
    // Enable with other bits set must not arm the change
    apb(1'b1, CTRL_ADDR, 32'hf0);
    apb(1'b0, CTRL_ADDR, 32'h0);
    cmp(rd, 32'h3);
    apb(1'b1, CTRL_ADDR, 32'h05);
    apb(1'b0, CTRL_ADDR, 32'h0);
    cmp(rd, 32'h3);
    apb(1'b0, 12'h00c, 32'h0);
    cmp({31'h0, err}, 32'h1);
    cmp(rd, 32'h0);
    // Late select write after the window has run out
    apb(1'b1, CTRL_ADDR, 32'h80);
    repeat (40) @(posedge pclk);
    apb(1'b1, CTRL_ADDR, 32'h01);
    apb(1'b0, CTRL_ADDR, 32'h0);
    cmp(rd, 32'h3);
    old = 8;
    for (int c = 0; c <= 8; c++) begin
      // Model core has no speed limit, every factor is safe
      chg(4'(c));
      per(p);
      cmp_cnt(p, 1, (old > (1 << c)) ? old : (1 << c));
      apb(1'b0, CTRL_ADDR, 32'h0);
      cmp(rd, 32'(c));
      apb(1'b0, STAT_ADDR, 32'h0);
      cmp({28'h0, rd[3:0]}, 32'(c));
      per(p);
      per(p);
      cmp_cnt(p, 1 << c, 1 << c);
      if (c > 0) begin
        cop(p);
        cop(p);
        cmp_cnt(p, 1 << c, 1 << c);
      end
      old = 1 << c;
    end
    chg(4'hc);
    apb(1'b0, CTRL_ADDR, 32'h0);
    cmp(rd, 32'h8);
    apb(1'b1, CTRL_ADDR, 32'h80);
    apb(1'b1, CTRL_ADDR, 32'h80);
    apb(1'b0, CTRL_ADDR, 32'h0);
    cmp(rd, 32'h88);
    repeat (4 * 256 + 64) @(posedge pclk);
    apb(1'b1, CTRL_ADDR, 32'h02);
    apb(1'b0, CTRL_ADDR, 32'h0);
    cmp(rd, 32'h8);
    conclude();
  end

  // Whole run is near 10k cycles
  initial begin
    repeat (60000) @(posedge pclk);
    err_total++;
    conclude();
  end

endmodule : tb_crystal_clock_prescaler_control
